// ===== rtl/media_scan.sv
/*
 * Background media scan scheduler: idle-time sequential scan in bursts and
 * segments, host yield, error logging/reallocation, pre-scan write-verify.
 * Assumes host and media inputs are synchronous to clk; media.done pulses once
 * per requested block after any recovery for it has finished.
 */
`timescale 1ns/10ps
module media_scan
    import scan_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire straps_t          straps,
    input  wire logic             host_cmd_pending,
    input  wire logic             host_cmd_arrive,
    input  wire logic             host_cmd_write,
    input  wire logic [LBA_W-1:0] host_cmd_lba,
    input  wire media_status_t    media,
    input  wire logic [LBA_W-1:0] total_blocks,
    input  wire logic             auto_read_reallocate_en,
    input  wire logic             read_continuous,
    input  wire logic             request_sense,
    input  wire logic             request_diag,
    input  wire logic [15:0]      arb_ids,
    input  wire logic             wide_bus,
    output logic                  scan_rd_req_r,
    output logic [LBA_W-1:0]      scan_rd_lba_r,
    output logic                  host_go_r,
    output logic                  write_verify_r,
    output log_entry_t            log_r,
    output logic                  realloc_req_r,
    output logic                  prescan_active_r,
    output logic                  scan_active_r,
    output log_entry_t            sense_r,
    output diag_t                 diag_r,
    output logic [ID_W-1:0]       bus_id_r,
    output logic                  arb_win_r
);
    localparam int unsigned SEG_W = $clog2(SEG_BLOCKS + 1);
    localparam int unsigned MS_W  = $clog2(BURST_MS + 1);

    if (CYC_MS < 2) begin : g_cyc_check
        $error("media_scan: CYC_MS must be at least 2");
    end

    scan_state_t       state_r;
    logic [MS_W-1:0]   ms_cnt_r;
    logic [SEG_W-1:0]  seg_cnt_r;
    logic [LBA_W-1:0]  pos_r;
    logic              straps_taken_r;
    logic              burst_pause_r;
    log_entry_t        last_err_r;
    logic              tick;
    logic              tick_clr;
    logic              idle_ok;
    logic              seg_end;
    logic              burst_end;
    logic              last_blk;
    logic [LBA_W-1:0]  pos_nxt;

    // Restart the ms base on phase changes except leaving S_RESUME, and on any host command arrival; a per-block restart would stall the burst clock
    assign tick_clr  = host_cmd_arrive || (state_r == S_WAIT && (host_cmd_pending || idle_ok))
                       || (state_r == S_READ && media.done && ((seg_end && host_cmd_pending) || burst_end || last_blk));
    assign last_blk  = (pos_r + LBA_W'(1) >= total_blocks);
    assign pos_nxt   = last_blk ? '0 : pos_r + LBA_W'(1);
    assign seg_end   = (seg_cnt_r == SEG_W'(SEG_BLOCKS - 1));
    assign burst_end = (ms_cnt_r >= MS_W'(BURST_MS));
    // Pre-scan skips the delay, except right after a burst so others get time
    assign idle_ok   = straps_taken_r && ((prescan_active_r && !burst_pause_r)
                       || ms_cnt_r >= MS_W'(IDLE_DELAY_MS));

    ms_tick #(
        .CYC (CYC_MS)
    ) u_tick (
        .clk    (clk),
        .reset  (reset),
        .clr    (tick_clr),
        .tick_r (tick)
    );

    // Arbitration rank: 7 highest, then down to 0, then 15 down to 8 on wide buses
    function automatic logic [4:0] prio(input logic [3:0] id);
        prio = id[3] ? {2'b00, id[2:0]} : {1'b0, 4'h8} + 5'({1'b0, id[2:0]});
    endfunction

    // Straps are caught once, on the first edge after reset release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            straps_taken_r <= 1'b0;
            bus_id_r       <= '0;
        end else if (!straps_taken_r) begin
            straps_taken_r <= 1'b1;
            bus_id_r       <= straps.bus_id;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            arb_win_r <= 1'b0;
        end else begin
            arb_win_r <= 1'b1;
            for (int i = 0; i < 16; i++) begin
                if (arb_ids[i] && (wide_bus || i < 8) && prio(4'(i)) > prio(bus_id_r))
                    arb_win_r <= 1'b0;
            end
            if (!arb_ids[bus_id_r])
                arb_win_r <= 1'b0;
        end
    end

    // Main scan sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r       <= S_WAIT;
            ms_cnt_r      <= '0;
            seg_cnt_r     <= '0;
            pos_r         <= '0;
            burst_pause_r <= 1'b0;
            scan_rd_req_r <= 1'b0;
            scan_rd_lba_r <= '0;
            host_go_r     <= 1'b0;
            scan_active_r <= 1'b0;
        end else begin
            scan_rd_req_r <= 1'b0;
            if (tick && ms_cnt_r != '1)
                ms_cnt_r <= ms_cnt_r + MS_W'(1);
            case (state_r)
                S_WAIT: begin
                    host_go_r <= straps_taken_r;
                    if (host_cmd_arrive || host_cmd_pending) begin
                        ms_cnt_r <= '0;
                    end else if (idle_ok) begin
                        state_r       <= S_READ;
                        ms_cnt_r      <= '0;
                        seg_cnt_r     <= '0;
                        burst_pause_r <= 1'b0;
                        scan_active_r <= 1'b1;
                        host_go_r     <= 1'b0;
                        scan_rd_req_r <= 1'b1;
                        scan_rd_lba_r <= pos_r;
                    end
                end
                S_READ: begin
                    // Host waits here until the block closing the segment or burst and its recovery end
                    host_go_r <= 1'b0;
                    if (media.done) begin
                        pos_r     <= pos_nxt;
                        seg_cnt_r <= seg_end ? '0 : seg_cnt_r + SEG_W'(1);
                        if (seg_end && host_cmd_pending) begin
                            state_r       <= S_RESUME;
                            ms_cnt_r      <= '0;
                            scan_active_r <= 1'b0;
                        end else if (burst_end || last_blk) begin
                            state_r       <= S_WAIT;
                            ms_cnt_r      <= '0;
                            burst_pause_r <= 1'b1;
                            scan_active_r <= 1'b0;
                        end else begin
                            scan_rd_req_r <= 1'b1;
                            scan_rd_lba_r <= pos_nxt;
                        end
                    end
                end
                S_RESUME: begin
                    // Overhead charged once; later commands find S_WAIT open
                    if (ms_cnt_r >= MS_W'(RESUME_MS)) begin
                        state_r   <= S_WAIT;
                        ms_cnt_r  <= '0;
                        host_go_r <= 1'b1;
                    end
                end
                default: state_r <= S_WAIT;
            endcase
        end
    end

    // Error sites from scan reads
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            log_r         <= '0;
            realloc_req_r <= 1'b0;
            last_err_r    <= '0;
            diag_r        <= '0;
            sense_r       <= '0;
        end else begin
            log_r.valid   <= 1'b0;
            realloc_req_r <= 1'b0;
            sense_r.valid <= 1'b0;
            diag_r.valid  <= 1'b0;
            if (state_r == S_READ && media.done && (media.unrecovered || media.recovered)) begin
                last_err_r <= '{valid: 1'b1, unrecovered: media.unrecovered, lba: pos_r};
                diag_r.errors <= diag_r.errors + CNT_W'(1);
                if (!media.unrecovered && auto_read_reallocate_en && !read_continuous && !media.limit_hit) begin
                    realloc_req_r <= 1'b1;
                    log_r.lba     <= pos_r;
                end else begin
                    log_r <= '{valid: 1'b1, unrecovered: media.unrecovered, lba: pos_r};
                end
            end
            if (state_r == S_READ && media.done && last_blk)
                diag_r.passes <= diag_r.passes + CNT_W'(1);
            if (request_sense)
                sense_r <= '{valid: 1'b1, unrecovered: last_err_r.unrecovered, lba: last_err_r.lba};
            if (request_diag)
                diag_r.valid <= 1'b1;
        end
    end

    // Pre-scan mode and write conversion
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prescan_active_r <= 1'b0;
            write_verify_r   <= 1'b0;
        end else begin
            if (!straps_taken_r)
                prescan_active_r <= straps.prescan;
            else if (state_r == S_READ && media.done && last_blk)
                prescan_active_r <= 1'b0;
            if (host_cmd_arrive)
                write_verify_r <= prescan_active_r && host_cmd_write && host_cmd_lba >= pos_r;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_seg_yield;
        state_r == S_READ && media.done && seg_end && host_cmd_pending;
    endsequence
    sequence s_resume_due;
        state_r == S_RESUME && ms_cnt_r >= MS_W'(RESUME_MS);
    endsequence
    property p_no_early_start;
        $rose(scan_active_r) && !$past(prescan_active_r) |-> $past(ms_cnt_r) >= MS_W'(IDLE_DELAY_MS);
    endproperty
    a_no_early_start: assert property (p_no_early_start) else $error("scan began before idle delay");
    property p_burst_limit;
        scan_active_r |-> ms_cnt_r <= MS_W'(BURST_MS + 1);
    endproperty
    a_burst_limit: assert property (p_burst_limit) else $error("burst ran past its limit");
    property p_seg_yield;
        s_seg_yield |=> state_r == S_RESUME && !scan_active_r;
    endproperty
    a_seg_yield: assert property (p_seg_yield) else $error("host not honoured at segment end");
    property p_seq_pos;
        state_r == S_READ && media.done && !last_blk |=> pos_r == $past(pos_r) + LBA_W'(1);
    endproperty
    a_seq_pos: assert property (p_seq_pos) else $error("scan position not sequential");
    property p_hold_host;
        state_r == S_READ |=> !host_go_r;
    endproperty
    a_hold_host: assert property (p_hold_host) else $error("host served during scan read");
    property p_resume_once;
        s_resume_due |=> state_r == S_WAIT && host_go_r;
    endproperty
    a_resume_once: assert property (p_resume_once) else $error("resume overhead not bounded");
    property p_unrec_logged;
        state_r == S_READ && media.done && media.unrecovered |=> log_r.valid && log_r.unrecovered;
    endproperty
    a_unrec_logged: assert property (p_unrec_logged) else $error("unrecovered site not logged");
    property p_realloc_gate;
        realloc_req_r |-> $past(auto_read_reallocate_en) && !$past(read_continuous) && !$past(media.limit_hit);
    endproperty
    a_realloc_gate: assert property (p_realloc_gate) else $error("reallocation without enable");
    property p_wv;
        host_cmd_arrive && host_cmd_write && prescan_active_r && host_cmd_lba >= pos_r |=> write_verify_r;
    endproperty
    a_wv: assert property (p_wv) else $error("pre-scan write not verified");
    property p_strap_hold;
        straps_taken_r && $past(straps_taken_r) |-> $stable(bus_id_r);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after power-up");
    property p_arrival_clears;
        host_cmd_arrive && state_r == S_WAIT |=> ms_cnt_r == '0;
    endproperty
    a_arrival_clears: assert property (p_arrival_clears) else $error("idle timer kept on arrival");
endmodule

// ===== rtl/scan_pkg.sv
/*
 * Constants and carrier types for the background media scan scheduler.
 * Assumes a single 250 MHz core clock; all times are derived from its period.
 */
package scan_pkg;
    localparam int unsigned CLK_PERIOD_PS   = 4000;
    localparam int unsigned PS_PER_MS       = 1000000000;
    localparam int unsigned CYC_PER_MS      = PS_PER_MS / CLK_PERIOD_PS;
    localparam int unsigned IDLE_DELAY_MS   = 500;
    localparam int unsigned BURST_MS        = 800;
    localparam int unsigned RESUME_MS       = 4;
    localparam int unsigned SEG_BLOCKS      = 400;
    localparam int unsigned LBA_W           = 32;
    localparam int unsigned ID_W            = 4;
    localparam int unsigned CNT_W           = 16;
    localparam logic [3:0]  TOP_PRIO_ID     = 4'h7;

    typedef struct packed {
        logic done;
        logic recovered;
        logic unrecovered;
        logic limit_hit;
    } media_status_t;

    typedef struct packed {
        logic            prescan;
        logic [ID_W-1:0] bus_id;
    } straps_t;

    typedef struct packed {
        logic             valid;
        logic             unrecovered;
        logic [LBA_W-1:0] lba;
    } log_entry_t;

    typedef struct packed {
        logic             valid;
        logic [CNT_W-1:0] passes;
        logic [CNT_W-1:0] errors;
    } diag_t;

    typedef enum logic [1:0] {
        S_WAIT,
        S_READ,
        S_RESUME
    } scan_state_t;
endpackage

// ===== rtl/ms_tick.sv
/*
 * Millisecond enable divider with synchronous restart.
 * Assumes clr is a one-cycle or level request from the same clock domain.
 */
`timescale 1ns/10ps
module ms_tick #(
    parameter int unsigned CYC = 250000
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clr,
    output logic      tick_r
);
    localparam int unsigned W = (CYC > 1) ? $clog2(CYC) : 1;
    localparam logic [W-1:0] LAST = W'(CYC - 1);
    logic [W-1:0] cnt_r;

    if (CYC < 2) begin : g_cyc_check
        $error("ms_tick: CYC must be at least 2");
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (clr) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (cnt_r == LAST);
            cnt_r  <= (cnt_r == LAST) ? '0 : cnt_r + W'(1);
        end
    end
endmodule

// ===== tb/host_model.sv
/*
 * Host initiator model: issues one command at a time to the scan scheduler.
 * Assumes calls arrive from the bench at falling clock edges.
 */
`timescale 1ns/10ps
module host_model
    import scan_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        go,
    output logic             pending,
    output logic             arrive,
    output logic             wr,
    output logic [LBA_W-1:0] lba
);
    initial begin
        pending = 1'b0;
        arrive  = 1'b0;
        wr      = 1'b0;
        lba     = '0;
    end

    // Busy time runs once the drive serves us, or after 9000 cycles unserved
    task automatic issue(input logic w, input logic [LBA_W-1:0] a);
        int n;
        pending = 1'b1;
        arrive  = 1'b1;
        wr      = w;
        lba     = a;
        @(negedge clk);
        arrive = 1'b0;
        wr     = ~w;
        lba    = ~a;
        n      = 0;
        while (go !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        repeat (5) @(negedge clk);
        pending = 1'b0;
    endtask
endmodule

// ===== tb/media_scan_test.sv
/*
 * Self-checking bench for media_scan with host model and a media responder.
 * Assumes CYC_MS shortened to 8; media answers each read in 1 to 3 cycles.
 */
`timescale 1ns/10ps
module media_scan_test;
    import scan_pkg::*;
    localparam int CM = 8;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    straps_t          straps = '0;
    media_status_t    media = '0;
    logic             pend, arrive, wr, go, wv, rd_req, realloc, ps_act, act, win;
    logic             rd_realloc = 1'b0, rd_cont = 1'b0, rq_s = 1'b0, rq_d = 1'b0, wide = 1'b0;
    logic [LBA_W-1:0] lba, rd_lba, nxt, l1, err_lba;
    logic [LBA_W-1:0] tot = 32'd1000;
    logic [15:0]      ids = '0;
    logic [15:0]      corner [4] = '{16'h0008, 16'h0088, 16'hff08, 16'h0018};
    logic [3:0]       id_o;
    logic [2:0]       e1;
    logic             act_q, go_q, err_unrec;
    log_entry_t       log_o, sense_o;
    diag_t            diag_o;
    int               seed = 32'hac51;
    int               cyc = 0, miscompares = 0, total_checks = 0;
    int               lat, blocks, stop_blk, stop_at, go_at, go_falls, passes, errs;

    always #2 clk = ~clk;

    host_model i_host_model (.clk(clk), .go(go), .pending(pend), .arrive(arrive), .wr(wr), .lba(lba));

    media_scan #(.CYC_MS(CM)) i_media_scan (
        .clk(clk), .reset(reset), .straps(straps), .host_cmd_pending(pend), .host_cmd_arrive(arrive),
        .host_cmd_write(wr), .host_cmd_lba(lba), .media(media), .total_blocks(tot),
        .auto_read_reallocate_en(rd_realloc), .read_continuous(rd_cont), .request_sense(rq_s), .request_diag(rq_d),
        .arb_ids(ids), .wide_bus(wide), .scan_rd_req_r(rd_req), .scan_rd_lba_r(rd_lba), .host_go_r(go),
        .write_verify_r(wv), .log_r(log_o), .realloc_req_r(realloc), .prescan_active_r(ps_act),
        .scan_active_r(act), .sense_r(sense_o), .diag_r(diag_o), .bus_id_r(id_o), .arb_win_r(win)
    );

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            summarize();
        end
    end

    // Media responder; idle status bits churn so stale values never pass
    always @(negedge clk) begin
        int r;
        r = $random(seed);
        if (reset) begin
            lat    = 0;
            nxt    = '0;
            e1     = 3'b000;
            passes = 0;
            errs   = 0;
        end else begin
            chk({log_o.valid, log_o.valid & log_o.unrecovered, realloc}, e1);
            if (e1 != 3'b000)
                chk(log_o.lba, l1);
            e1 = 3'b000;
            if (act && !act_q)
                blocks = 0;
            if (!act && act_q) begin
                stop_blk = blocks;
                stop_at  = cyc;
            end
            if (go && !go_q) begin
                go_at = cyc;
                chk(lat, 0);
            end
            if (!go && go_q)
                go_falls++;
            media = {1'b0, r[2:0]};
            if (rd_req) begin
                chk(rd_lba, nxt);
                lat = 1 + r[5:4] % 3;
            end else if (lat > 0) begin
                lat--;
                if (lat == 0) begin
                    media = {1'b1, r[2:0] == 3'd1, r[2:0] == 3'd0, r[3]};
                    l1    = nxt;
                    if (r[2:0] < 3'd2) begin
                        errs++;
                        err_lba   = nxt;
                        err_unrec = r[2:0] == 3'd0;
                    end
                    e1 = r[2:0] == 3'd0 ? 3'b110 : r[2:0] == 3'd1 ? (rd_realloc & !rd_cont & !r[3] ? 3'b001 : 3'b100) : 3'b000;
                    nxt = nxt + 1 == tot ? '0 : nxt + 1;
                    passes += (nxt == 0);
                    blocks++;
                end
            end
        end
        act_q = act;
        go_q  = go;
    end

    task automatic do_reset(input logic p, input logic [LBA_W-1:0] t);
        reset  = 1'b1;
        straps = '{prescan: p, bus_id: 4'h3}; // unlike the host's id 7
        tot    = t;
        rd_realloc = !p;
        rd_cont    = p;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        straps = '{prescan: !p, bus_id: 4'h5};
        @(negedge clk);
        chk({id_o, ps_act}, {4'h3, p});
    endtask

    task automatic wait_act(input logic lvl, output int k);
        k = 0;
        while (act !== lvl && k < 9000) begin
            @(negedge clk);
            k++;
        end
    endtask

    task automatic report();
        rq_s = 1'b1;
        rq_d = 1'b1;
        @(negedge clk);
        rq_s = 1'b0;
        rq_d = 1'b0;
        chk({sense_o.valid, sense_o.unrecovered, sense_o.lba}, {2'b11 & {1'b1, err_unrec}, err_lba});
        chk({diag_o.valid, diag_o.passes, diag_o.errors}, {1'b1, passes[15:0], errs[15:0]});
    endtask

    // Corner patterns first, then random ones; own id is 3
    initial begin
        int k;
        do_reset(1'b0, 32'h0010_0000);
        wait_act(1'b1, k);
        chk(k > 500*CM-4 && k < 502*CM, 1'b1);
        wait_act(1'b0, k);
        chk(k > 799*CM && k < 802*CM, 1'b1);
        repeat (300*CM) @(negedge clk);
        i_host_model.issue(1'b1, 32'h000f_0000);
        chk(wv, 1'b0);
        wait_act(1'b1, k);
        chk(k > 500*CM-4 && k < 502*CM, 1'b1);
        repeat (100) @(negedge clk);
        i_host_model.issue(1'b0, 32'h0);
        chk(stop_blk, 400);
        chk(go_at - stop_at >= RESUME_MS*CM-1 && go_at - stop_at <= RESUME_MS*CM+3, 1'b1);
        k = go_falls;
        @(negedge clk);
        i_host_model.issue(1'b1, 32'h0);
        chk(go_falls, k);
        report();
        for (int i = 0; i < 40; i++) begin
            wide = i < 4 ? 1'b1 : 1'(($random(seed)));
            ids  = i < 4 ? corner[i] : 16'($random(seed));
            if (!wide)
                ids[15:8] = 8'h00;
            @(negedge clk);
            @(negedge clk);
            chk(win, ids[3] & ~|ids[7:4]);
        end
        do_reset(1'b1, 32'd1000);
        wait_act(1'b1, k);
        chk(k < 4, 1'b1);
        repeat (20) @(negedge clk);
        i_host_model.issue(1'b1, 32'd999);
        chk(wv, 1'b1);
        wait_act(1'b1, k);
        chk(k < 4, 1'b1);
        i_host_model.issue(1'b1, 32'd0);
        chk(wv, 1'b0);
        wait_act(1'b1, k);
        wait_act(1'b0, k);
        chk({ps_act, nxt == 0}, 2'b01);
        @(negedge clk);
        i_host_model.issue(1'b1, 32'd999);
        chk(wv, 1'b0);
        report();
        summarize();
    end
endmodule
